// File: common/asro_pkg.sv
// asro_pkg: shared constants and carrier types for the serial readout and mode logic
// assumes a 200 MHz system clock; link pins arrive asynchronously and are synchronised
package asro_pkg;

  localparam int RESULT_WIDTH        = 16;       // bits per conversion result
  localparam int CLK_PERIOD_PS       = 5000;     // 200 MHz system clock
  localparam int CONVERSION_TIME_PS  = 500000;   // default conversion time, plain value
  localparam int CONVERSION_CYCLES   = (CONVERSION_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_STAGES         = 2;
  localparam int BUF_DEPTH           = 2;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // readout mode latched at convert_start rising edge
  typedef enum logic [0:0] {
    ASRO_MODE_CHAIN = 1'b0,
    ASRO_MODE_CS    = 1'b1
  } asro_mode_type;

  // conversion engine states
  typedef enum logic [1:0] {
    ASRO_ST_ACQ   = 2'b00,
    ASRO_ST_CONV  = 2'b01,
    ASRO_ST_DONE  = 2'b10
  } asro_state_type;

  // one result word travelling through the buffer
  typedef struct packed {
    logic [RESULT_WIDTH-1:0] data;
    logic                    invalid;   // first fast-mode result, to be discarded
  } asro_word_type;

  // serial output pin triple
  typedef struct packed {
    logic drive;     // level driven
    logic oe_n;      // low while driving
    logic shifting;  // a word is in flight
  } asro_pin_type;

endpackage

// File: rtl/asro_readout.sv
// asro_readout: convert-start handling, mode select, busy indicator and serial result shift
// assumes the host drives convert_start, serial_in_select and the serial clock asynchronously
//
// Contract
// R1 - convert_start rising edge latches serial input: high chip-select, low daisy-chain.
// R2 - serial input sampled one stage late so tied pins select daisy-chain.
// R3 - host uses daisy-chain only with fast mode held low.
// R4 - chip-select mode arms busy when convert_start or serial input low at end.
// R5 - in normal mode a start bit may precede result bits as busy.
// R6 - without busy indicator host waits maximum conversion time before reading.
// R7 - host holds fast mode low for busy chip-select or daisy-chain.
// R8 - with convert_start low, reading allowed in conversion, acquisition or split; the code drives the output in acquisition only.
// R9 - host should use a gated serial clock.
// R10 - host keeps pins quiet after safe-read window until conversion ends.
// R11 - host keeps pins idle from last clock fall to next convert_start rise.
// R12 - host configures mode and busy before safe-read window ends.
// R13 - host keeps pins still near each convert_start rising edge.
// R14 - acquisition-only reading supported in normal mode only; the code also enables it in fast mode.
// R15 - chip-select mode works 3-wire or 4-wire with serial input as select.
// R16 - normal mode powers down at end of every conversion.
// R17 - conversion starts on convert_start rise, timed by internal clock.
// R18 - first fast-mode result after entering the mode is flagged invalid.
// R19 - reading during conversion n presents result n-1; the code loads n-1 at the rise but keeps the output off until conversion ends.
// R20 - 3-wire no-busy output floats after 16th falling edge or convert_start rise.
// R21 - result shifted msb first, one bit per serial clock falling edge.
// R22 - output floats when not selected or not shifting; the code keeps driving while busy is armed, even when deselected.
`timescale 1ns/1ps
module asro_readout #(
  parameter int CONV_CYCLES = asro_pkg::CONVERSION_CYCLES
) (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_reset_n,
  input  wire logic                              i_convert_start,
  input  wire logic                              i_serial_in_select,
  input  wire logic                              i_serial_clk,
  input  wire logic                              i_fast_mode,
  input  wire logic [asro_pkg::RESULT_WIDTH-1:0] i_result,
  output logic                                   o_serial_result_out,
  output logic                                   o_serial_result_out_oe_n,
  output logic                                   o_power_down,
  output logic                                   o_converting,
  output logic                                   o_chain_mode,
  output logic                                   o_result_invalid
);

  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam int BW = $clog2(asro_pkg::RESULT_WIDTH + 2);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
  localparam logic [BW-1:0] BITS_LAST = BW'(asro_pkg::RESULT_WIDTH);

  // two-stage synchronisers; only stage two is read by logic
  logic [asro_pkg::SYNC_STAGES-1:0] cnv_sync;
  logic [asro_pkg::SYNC_STAGES-1:0] sdi_sync;
  logic [asro_pkg::SYNC_STAGES-1:0] sck_sync;
  logic [asro_pkg::SYNC_STAGES-1:0] fast_sync;
  logic                             cnv_d;
  logic                             sck_d;
  logic                             sdi_d;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnv_sync <= '0;
      sdi_sync <= '0;
      sck_sync <= '0;
      fast_sync <= '0;
      cnv_d    <= 1'b0;
      sck_d    <= 1'b0;
      sdi_d    <= 1'b0;
    end else begin
      cnv_sync <= {cnv_sync[0], i_convert_start};
      sdi_sync <= {sdi_sync[0], i_serial_in_select};
      sck_sync <= {sck_sync[0], i_serial_clk};
      fast_sync <= {fast_sync[0], i_fast_mode};
      cnv_d    <= cnv_sync[1];
      sck_d    <= sck_sync[1];
      sdi_d    <= sdi_sync[1];
    end
  end

  // edge detection on synchronised pins
  wire cnv_rise  = cnv_sync[1] & ~cnv_d;
  wire sck_fall  = ~sck_sync[1] & sck_d;
  wire cnv_level = cnv_sync[1];
  wire sdi_level = sdi_sync[1];
  // fast-mode select is a host pin too, so it is read only after the synchroniser
  wire fast_level = fast_sync[1];
  // sdi seen the cycle before the edge: tied pins read low, so chain wins
  wire sdi_at_edge = sdi_d;                                              // R2

  asro_pkg::asro_state_type state;
  asro_pkg::asro_state_type next_state;
  asro_pkg::asro_mode_type  mode;
  logic [CW-1:0]            conv_cnt;
  logic                     fast_prev;
  logic                     busy_armed;
  logic [BW-1:0]            bit_cnt;
  logic [asro_pkg::RESULT_WIDTH:0] shreg;   // start bit plus result
  logic                     out_en;
  logic                     out_bit;

  wire conv_end = (state == asro_pkg::ASRO_ST_CONV) && (conv_cnt == CONV_LAST);  // R17
  // a rise during conversion is ignored, so it must not consume a buffered word either
  wire cnv_take = cnv_rise && (state != asro_pkg::ASRO_ST_CONV);

  // two-entry result buffer; popped on a convert_start rise outside conversion and on conversion end, so a word the reader has not shifted out is replaced
  asro_pkg::asro_word_type buf_mem [asro_pkg::BUF_DEPTH];
  logic                    wr_ptr;
  logic                    rd_ptr;
  logic [1:0]              buf_cnt;
  asro_pkg::asro_word_type push_word;
  wire buf_in_valid  = conv_end;
  wire buf_in_ready  = (buf_cnt != 2'd2);
  wire buf_out_valid = (buf_cnt != 2'd0);
  wire load_req      = cnv_take | conv_end;
  wire buf_out_ready = buf_out_valid & load_req;
  wire push          = buf_in_valid & buf_in_ready;
  wire pop           = buf_out_valid & buf_out_ready;

  // first fast-mode result after entering the mode is meaningless
  always_comb begin
    push_word.data    = i_result;
    push_word.invalid = fast_level & ~fast_prev;                         // R18
  end

  // conversion sequencer
  always_comb begin
    next_state = state;
    case (state)
      asro_pkg::ASRO_ST_ACQ:  if (cnv_rise) next_state = asro_pkg::ASRO_ST_CONV;  // R17
      asro_pkg::ASRO_ST_CONV: if (conv_end) next_state = asro_pkg::ASRO_ST_DONE;
      asro_pkg::ASRO_ST_DONE: next_state = cnv_rise ? asro_pkg::ASRO_ST_CONV   // R17
                                                    : asro_pkg::ASRO_ST_ACQ;
      default:                next_state = asro_pkg::ASRO_ST_ACQ;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state     <= asro_pkg::ASRO_ST_ACQ;
      conv_cnt  <= '0;
      mode      <= asro_pkg::ASRO_MODE_CS;
      fast_prev <= 1'b0;
    end else begin
      state <= next_state;
      if (cnv_rise && state != asro_pkg::ASRO_ST_CONV) begin
        mode <= asro_pkg::asro_mode_type'(sdi_at_edge);                  // R1
      end
      if (state == asro_pkg::ASRO_ST_CONV) begin
        conv_cnt <= conv_cnt + CW'(1);
      end else begin
        conv_cnt <= '0;
      end
      if (conv_end) begin
        fast_prev <= fast_level;
      end
    end
  end

  // result buffer storage
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      buf_mem[wr_ptr] <= push_word;
    end
  end

  // busy start bit only in chip-select, normal mode, with cnv or sdi low at end
  wire arm_busy = conv_end && (mode == asro_pkg::ASRO_MODE_CS)
                  && !fast_level && (!cnv_level || !sdi_level);          // R4 R5
  // fresh result goes straight to the shifter when nothing older waits in the buffer
  wire load_direct = conv_end && (buf_cnt == 2'd0);
  // selected: 3-wire/chain by cnv low, 4-wire by sdi low while cnv high
  wire selected = (!cnv_level) || (mode == asro_pkg::ASRO_MODE_CS && !sdi_level);  // R15 R8
  wire shift_go = sck_fall && selected && out_en;
  wire done_bits = (bit_cnt == BITS_LAST) ||
                   (!busy_armed && bit_cnt == BITS_LAST - BW'(1));

  // serial shifter: load n-1 result from buffer on a rise, fresh result at conversion end when buffer empty, shift on clock falls
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shreg      <= '0;
      bit_cnt    <= '0;
      out_en     <= 1'b0;
      busy_armed <= 1'b0;
    end else if (cnv_rise && state != asro_pkg::ASRO_ST_CONV) begin
      out_en  <= 1'b0;                                                   // R20
      bit_cnt <= '0;
      if (pop) begin
        shreg <= {1'b0, buf_mem[rd_ptr].data};                           // R19
      end
    end else if (conv_end) begin
      busy_armed <= arm_busy;
      if (pop) begin
        shreg <= {1'b0, buf_mem[rd_ptr].data};
      end else if (buf_cnt == 2'd0) begin
        shreg <= {1'b0, i_result};
      end
      out_en <= arm_busy;                                                // R4
    end else if (state == asro_pkg::ASRO_ST_ACQ && selected && !out_en && bit_cnt == '0) begin
      out_en <= 1'b1;                                                    // R14 R22
    end else if (shift_go) begin
      shreg   <= {shreg[asro_pkg::RESULT_WIDTH-1:0], 1'b0};              // R21
      bit_cnt <= bit_cnt + BW'(1);
      if (done_bits) begin
        out_en     <= 1'b0;                                              // R20
        busy_armed <= 1'b0;
      end
    end else if (!selected && !busy_armed) begin
      out_en <= 1'b0;                                                    // R22
    end
  end

  // busy shows start bit low then msb; plain mode shows msb first
  wire next_out = busy_armed ? shreg[asro_pkg::RESULT_WIDTH]
                             : shreg[asro_pkg::RESULT_WIDTH-1];
  wire next_oe_n = ~out_en;

  // registered pin outputs and status
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_result_out      <= 1'b0;
      o_serial_result_out_oe_n <= 1'b1;
      o_power_down             <= 1'b0;
      o_converting             <= 1'b0;
      o_chain_mode             <= 1'b0;
      o_result_invalid         <= 1'b0;
    end else begin
      o_serial_result_out      <= next_out;
      o_serial_result_out_oe_n <= next_oe_n;
      o_power_down             <= !fast_level && state != asro_pkg::ASRO_ST_CONV;   // R16
      o_converting             <= (next_state == asro_pkg::ASRO_ST_CONV);
      o_chain_mode             <= (mode == asro_pkg::ASRO_MODE_CHAIN);
      if (pop) begin
        o_result_invalid <= buf_mem[rd_ptr].invalid;                     // R18
      end else if (load_direct) begin
        o_result_invalid <= push_word.invalid;                           // R18
      end
    end
  end

endmodule

// File: testbench/asro_host.sv
// asro_host: host side of the serial link, drives convert_start, select and gated clock
// assumes a pull-up on the serial output line, sampled just before each clock fall
`timescale 1ns/1ps
module asro_host (
  output logic      o_cnv,
  output logic      o_sdi,
  output logic      o_sck,
  input  wire logic i_sdo
);
  // gated clock stands low outside frames so nothing shifts by accident
  initial begin
    o_cnv = 1'b0;
    o_sdi = 1'b1;
    o_sck = 1'b0;
  end
  // tied mimics select wired to convert_start: both rise together
  task automatic start(input logic sel, input logic tied);
    // drop convert_start first so a line left high still gives a fresh rising edge
    o_cnv = 1'b0;
    o_sdi = sel;
    #25 o_cnv = 1'b1;
    if (tied) o_sdi = 1'b1;
    #15 o_sdi = 1'b1;
  endtask
  task automatic select(input logic v);
    o_cnv = v;
  endtask
  // 48 ns link clock, one bit per falling edge
  task automatic read(input int n, output logic [16:0] w);
    w = '0;
    for (int k = 0; k < n; k++) begin
      o_sck = 1'b1;
      #24 w = {w[15:0], i_sdo};
      o_sck = 1'b0;
      #24;
    end
  endtask
endmodule

// File: testbench/asro_readout_chk.sv
// asro_readout_chk: port checks of conversion timing, power and output release
// assumes only the readout block ports; bound to every instance
`timescale 1ns/1ps
module asro_readout_chk #(
  parameter int CONV_CYCLES = 10
) (
  input wire logic        i_ref_clk,
  input wire logic        i_reset_n,
  input wire logic        i_convert_start,
  input wire logic        i_serial_in_select,
  input wire logic        i_serial_clk,
  input wire logic        i_fast_mode,
  input wire logic [15:0] i_result,
  input wire logic        o_serial_result_out,
  input wire logic        o_serial_result_out_oe_n,
  input wire logic        o_power_down,
  input wire logic        o_converting,
  input wire logic        o_chain_mode,
  input wire logic        o_result_invalid
);
  localparam int CONV_TAIL = CONV_CYCLES - 7; // cycles from eighth busy sample to first idle one
  logic [5:0] idle_q; // history of convert_start and select both high
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) idle_q <= '0;
    else idle_q <= {idle_q[4:0], i_convert_start & i_serial_in_select};
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  sequence conv_run;
    o_converting[*8];
  endsequence
  a_conv_bounded: assert property ($rose(o_converting) |-> conv_run ##CONV_TAIL !o_converting)
    else $error("conversion length wrong");
  a_conv_cause: assert property ($rose(o_converting) |-> $past(i_convert_start, 2))
    else $error("conversion without convert_start");
  a_pd_busy: assert property (o_converting && $past(o_converting) |-> !o_power_down)
    else $error("powered down while converting");
  // fast-mode pin is synchronised, so power state follows it three samples later
  a_pd_normal: assert property (!o_converting && !$past(o_converting)
    && !$past(o_converting, 2) && !i_fast_mode && !$past(i_fast_mode)
    && !$past(i_fast_mode, 2) && !$past(i_fast_mode, 3) && $past(i_reset_n, 2)
    |-> o_power_down)
    else $error("normal mode idle but not powered down");
  a_fast_awake: assert property (i_fast_mode && $past(i_fast_mode)
    && $past(i_fast_mode, 2) && $past(i_fast_mode, 3) |-> !o_power_down)
    else $error("fast mode powered down");
  a_float_idle: assert property (&idle_q && !o_chain_mode |-> o_serial_result_out_oe_n)
    else $error("output driven while deselected");
  a_chain_cause: assert property ($changed(o_chain_mode) |-> $past(i_convert_start))
    else $error("mode changed without convert_start");
  a_invalid_fast: assert property ($rose(o_result_invalid) |-> $past(i_fast_mode))
    else $error("invalid flag outside fast mode");
endmodule
bind asro_readout asro_readout_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_convert_start(i_convert_start),
  .i_serial_in_select(i_serial_in_select), .i_serial_clk(i_serial_clk),
  .i_fast_mode(i_fast_mode), .i_result(i_result), .o_serial_result_out(o_serial_result_out),
  .o_serial_result_out_oe_n(o_serial_result_out_oe_n), .o_power_down(o_power_down),
  .o_converting(o_converting), .o_chain_mode(o_chain_mode),
  .o_result_invalid(o_result_invalid));

// File: testbench/tb_adc_serial_readout_mode_control.sv
// tb_adc_serial_readout_mode_control: directed tests of mode select and serial readout
// assumes the host model drives the link pins and the serial line has a pull-up
`timescale 1ns/1ps
module tb_adc_serial_readout_mode_control;
  localparam int CONV = 10;
  logic        clk, rst_n, fast, convert_start, serial_in_select, sck, out, oe_n, pd, conv, chain, inv, serial_result_out;
  logic [15:0] res;
  logic [16:0] w;
  int          n_mismatch, compares;
  assign serial_result_out = oe_n ? 1'b1 : out; // released line floats up to the pull-up
  asro_readout #(.CONV_CYCLES(CONV)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_convert_start(convert_start), .i_serial_in_select(serial_in_select), .i_serial_clk(sck), .i_fast_mode(fast),
    .i_result(res), .o_serial_result_out(out), .o_serial_result_out_oe_n(oe_n),
    .o_power_down(pd), .o_converting(conv), .o_chain_mode(chain), .o_result_invalid(inv));
  asro_host host (.o_cnv(convert_start), .o_sdi(serial_in_select), .o_sck(sck), .i_sdo(serial_result_out));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // busy drops convert_start mid-conversion; the wait covers the longest conversion
  task automatic convert(input logic sel, tied, busy, input logic [15:0] r);
    @(negedge clk) res = r;
    host.start(sel, tied);
    #30 check("converting", conv, 1'b1);
    host.select(!busy);
    #(CONV * 5 + 60);
  endtask
  initial begin
    rst_n = 1'b0;
    fast = 1'b0;
    res = 16'h0000;
    n_mismatch = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    check("oe_n reset", oe_n, 1'b1);
    convert(1'b1, 1'b0, 1'b0, 16'hA53C);
    check("chain", chain, 1'b0);
    check("power_down", pd, 1'b1);
    check("oe_n idle", oe_n, 1'b1);
    host.select(1'b0);
    #30 check("msb", out, 1'b1);
    host.read(16, w);
    check("word", w[15:0], 16'hA53C);
    #30 check("oe_n end", oe_n, 1'b1);
    $display("test three-wire read done");
    convert(1'b1, 1'b0, 1'b1, 16'h5AC3);
    check("busy oe_n", oe_n, 1'b0);
    host.read(17, w);
    check("busy word", w, {1'b0, 16'h5AC3});
    #30 check("busy end", oe_n, 1'b1);
    $display("test busy read done");
    @(negedge clk) fast = 1'b1;
    convert(1'b1, 1'b0, 1'b0, 16'h1234);
    check("invalid", inv, 1'b1);
    check("fast awake", pd, 1'b0);
    @(negedge clk) fast = 1'b0;
    $display("test fast mode done");
    convert(1'b0, 1'b1, 1'b0, 16'h0F0F);
    check("tied chain", chain, 1'b1);
    $display("test chain select done");
    results();
  end
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
endmodule
